// [spi_port_pkg.sv]
// spi_port_pkg: register map, field positions, reset values and carriers
// for the byte-wide serial port; assumes an APB slave with 8-bit addressing
package spi_port_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;
   localparam int HALF_W = 12;
   localparam int PIN_N = 4;

   // byte addresses, one 32-bit word per register
   localparam logic [ADDR_W-1:0] ADDR_CONTROL_ONE = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_MATCH = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_CONTROL_TWO = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_BAUD = 8'h0c;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h14;

   // control_one fields
   localparam int C1_IRQ_EN = 7;
   localparam int C1_ENABLE = 6;
   localparam int C1_TX_IRQ_EN = 5;
   localparam int C1_MASTER = 4;
   localparam int C1_CPOL = 3;
   localparam int C1_CPHA = 2;
   localparam int C1_SELECT_OUTPUT_ENABLE = 1;
   localparam int C1_BIT_ORDER_LOWFIRST = 0;
   // control_two fields
   localparam int C2_MODE_FAULT_ENABLE = 4;
   localparam int C2_BIDIR_OUTPUT_ENABLE = 3;
   localparam int C2_PINMODE = 0;
   // status fields
   localparam int ST_RXFULL = 7;
   localparam int ST_MATCH = 6;
   localparam int ST_TXEMPTY = 5;
   localparam int ST_MODE_FAULT_FLAG = 4;
   // baud fields
   localparam int PPR_LSB = 4;
   localparam int PPR_W = 3;
   localparam int SPR_W = 4;
   localparam logic [SPR_W-1:0] SPR_MAX = 4'h8;

   localparam logic [DATA_W-1:0] C1_RESET = 8'h04;
   localparam logic [DATA_W-1:0] C2_RESET = 8'h00;
   localparam logic [DATA_W-1:0] BAUD_RESET = 8'h00;
   localparam logic [DATA_W-1:0] MATCH_RESET = 8'h00;
   localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
   localparam logic [DATA_W-1:0] C1_ABORT_MASK = 8'h0f;
   localparam logic [DATA_W-1:0] C2_ABORT_MASK = 8'h11;
   localparam logic [DATA_W-1:0] BAUD_ABORT_MASK = 8'h7f;

   localparam logic [3:0] EDGE_FIRST = 4'h0;
   localparam logic [3:0] EDGE_LAST = 4'hf;
   localparam logic [HALF_W-1:0] HALF_ONE = 12'h001;
   localparam logic [HALF_W-1:0] HALF_ZERO = 12'h000;

   // pin index inside pin_in_type seen as a vector
   localparam int PIN_SS = 3;
   localparam int PIN_SCLK = 2;
   localparam int PIN_MOSI = 1;
   localparam int PIN_MISO = 0;
   localparam logic [PIN_N-1:0] PIN_IDLE = 4'h8;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_type;

   typedef struct packed {
      logic ss;
      logic sclk;
      logic mosi;
      logic miso;
   } pin_in_type;

   typedef struct packed {
      logic ssOut;
      logic select_output_enable;
      logic sclkOut;
      logic sclkOe;
      logic mosiOut;
      logic mosiOe;
      logic misoOut;
      logic misoOe;
   } pin_out_type;

   typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_TRAIL} xfer_state_type;
endpackage

// [spi_master_slave_port.sv]
// spi_master_slave_port: byte-wide serial port, master or slave, APB registers
// assumes pins are resolved outside from out/oe pairs; single clock clk
//
// How it works
// R1 - phase 0 puts first clock edge mid first bit; phase 1 at its start
// R2 - master without fault enable leaves select pin as general I/O; slave reads it
// R3 - master with fault enable: select is auto output or fault input per enable
// R4 - bit order 0 sends most significant bit first, 1 least significant first
// R5 - data register always holds the most significant bit in bit 7
// R6 - each byte entering receive buffer compared with match value; equal sets flag
// R7 - data write fills transmit buffer; master sends it once prior transfer ends
// R8 - data write ignored unless status was read with transmit-empty set
// R9 - byte finishing while receive buffer full is dropped, old byte kept
// R10 - software reads each byte before the next transfer completes
// R11 - system enable hands all four pins to the serial function; code leaves select as general I/O for a master without fault enable
// R12 - completed byte moves from shifter into receive buffer
// R13 - polarity inverts clock; phase picks odd or even sampling edges
// R14 - master bit selects master; only master starts transfers
// R15 - master byte written with shifter empty loads at once and shifts out
// R16 - master clock from baud generator of rate and prescale bits
// R17 - automatic select is low during transfers, high when idle
// R18 - select low as fault input: drop master, release outputs, abort, flag
// R19 - interrupt requested when fault flag sets with its enable on
// R20 - master waits half a clock period after start before first edge
// R21 - master config change aborts transfer and forces idle
// R22 - master software must itself return the remote slave to idle
// R23 - clearing system enable forces idle and resets every status flag
// R24 - polarity 0 idles clock low, 1 idles it high
// R25 - each transfer is exactly sixteen clock edges, eight bits
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_port (
   input wire logic clk,
   input wire logic reset,
   input wire spi_port_pkg::apb_req_type apbReq,
   output spi_port_pkg::apb_rsp_type apbRsp,
   input wire spi_port_pkg::pin_in_type pinIn,
   output spi_port_pkg::pin_out_type pinOut,
   output logic irq
);
   import spi_port_pkg::*;

   function automatic logic [DATA_W-1:0] shiftIn(input logic [DATA_W-1:0] v, input logic b,
                                                 input logic lsb);
      shiftIn = lsb ? {b, v[DATA_W-1:1]} : {v[DATA_W-2:0], b};
   endfunction

   // pin input conditioning
   logic [PIN_N-1:0] pinVec;
   logic [PIN_N-1:0] s1_r, s2_r, s3_r, pinF_r, pinF_nxt;

   // register group
   apb_rsp_type rsp_r, rsp_nxt;
   logic [DATA_W-1:0] c1_r, c1_nxt, c2_r, c2_nxt, baud_r, baud_nxt, match_r, match_nxt;
   logic [DATA_W-1:0] txBuf_r, txBuf_nxt, rxBuf_r, rxBuf_nxt;
   logic rxFull_r, rxFull_nxt, matchFlag_r, matchFlag_nxt, txEmpty_r, txEmpty_nxt;
   logic mode_fault_flag_r, mode_fault_flag_nxt, armTx_r, armTx_nxt, modfArm_r, modfArm_nxt, irq_r, irq_nxt;

   // engine group
   xfer_state_type state_r, state_nxt;
   logic [DATA_W-1:0] sh_r, sh_nxt, shFinal;
   logic [3:0] edgeCnt_r, edgeCnt_nxt;
   logic [HALF_W-1:0] halfCnt_r, halfCnt_nxt, halfLen;
   logic [SPR_W-1:0] sprEff;
   logic sclkPhase_r, sclkPhase_nxt, latch_r, latch_nxt, sclkPrev_r, sclkPrev_nxt;
   logic takeTx, complete, tick, edgeEvt, inBit, outBit, sampleE, shiftE;

   // pin output group
   pin_out_type pinOut_r, pinOut_nxt;

   // shared decode
   logic [DATA_W-1:0] wData;
   logic setup, wrAcc, rdAcc, enable, masterOn, autoSs, fault, cfgAbort, selected;
   logic lsb, cpha, single_wire_pin_mode;

   assign pinVec = pinIn;
   assign wData = apbReq.pwdata[DATA_W-1:0];
   assign setup = apbReq.psel && !apbReq.penable;
   assign wrAcc = apbReq.psel && apbReq.penable && rsp_r.pready && apbReq.pwrite;
   assign rdAcc = apbReq.psel && apbReq.penable && rsp_r.pready && !apbReq.pwrite;
   assign enable = c1_r[C1_ENABLE];
   assign masterOn = enable && c1_r[C1_MASTER];
   assign lsb = c1_r[C1_BIT_ORDER_LOWFIRST];
   assign cpha = c1_r[C1_CPHA];
   assign single_wire_pin_mode = c2_r[C2_PINMODE];
   assign autoSs = masterOn && c2_r[C2_MODE_FAULT_ENABLE] && c1_r[C1_SELECT_OUTPUT_ENABLE];
   assign selected = enable && !c1_r[C1_MASTER] && !pinF_r[PIN_SS];
   assign fault = masterOn && c2_r[C2_MODE_FAULT_ENABLE] && !c1_r[C1_SELECT_OUTPUT_ENABLE] && !pinF_r[PIN_SS]; // R3
   assign cfgAbort = masterOn && wrAcc && (
      (apbReq.paddr == ADDR_CONTROL_ONE && ((wData ^ c1_r) & C1_ABORT_MASK) != '0) ||
      (apbReq.paddr == ADDR_CONTROL_TWO && (((wData ^ c2_r) & C2_ABORT_MASK) != '0 ||
         (single_wire_pin_mode && wData[C2_BIDIR_OUTPUT_ENABLE] != c2_r[C2_BIDIR_OUTPUT_ENABLE]))) ||
      (apbReq.paddr == ADDR_BAUD && ((wData ^ baud_r) & BAUD_ABORT_MASK) != '0)); // R21

   // three-stage capture; a change counts once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < PIN_N; gi++) begin : g_filt
         assign pinF_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s2_r[gi] : pinF_r[gi];
      end
   endgenerate

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s1_r <= PIN_IDLE;
         s2_r <= PIN_IDLE;
         s3_r <= PIN_IDLE;
         pinF_r <= PIN_IDLE;
      end else begin
         s1_r <= pinVec;
         s2_r <= s1_r;
         s3_r <= s2_r;
         pinF_r <= pinF_nxt;
      end
   end

   // baud generator: half period = (prescale + 1) << rate clocks
   always_comb begin
      sprEff = (baud_r[SPR_W-1:0] > SPR_MAX) ? SPR_MAX : baud_r[SPR_W-1:0];
      halfLen = HALF_W'({1'b0, baud_r[PPR_LSB +: PPR_W]} + 4'h1) << sprEff; // R16
   end

   // transfer engine, shared by master and slave
   always_comb begin
      state_nxt = state_r;
      sh_nxt = sh_r;
      edgeCnt_nxt = edgeCnt_r;
      halfCnt_nxt = halfCnt_r;
      sclkPhase_nxt = sclkPhase_r;
      latch_nxt = latch_r;
      sclkPrev_nxt = pinF_r[PIN_SCLK];
      takeTx = 1'b0;
      complete = 1'b0;
      shFinal = sh_r;
      tick = (halfCnt_r == HALF_ZERO);
      outBit = lsb ? sh_r[0] : sh_r[DATA_W-1]; // R4
      if (c1_r[C1_MASTER]) begin
         inBit = single_wire_pin_mode ? pinF_r[PIN_MOSI] : pinF_r[PIN_MISO];
      end else begin
         inBit = single_wire_pin_mode ? pinF_r[PIN_MISO] : pinF_r[PIN_MOSI];
      end
      if (c1_r[C1_MASTER]) begin
         edgeEvt = (state_r == ST_ACTIVE) && tick;
      end else begin
         edgeEvt = (state_r == ST_ACTIVE) && selected && (pinF_r[PIN_SCLK] != sclkPrev_r);
      end
      // odd edges sample with phase 0, even edges with phase 1
      sampleE = edgeCnt_r[0] ^ !cpha; // R13
      shiftE = !sampleE && !(cpha && edgeCnt_r == EDGE_FIRST);
      if (state_r != ST_IDLE) begin
         halfCnt_nxt = tick ? halfLen - HALF_ONE : halfCnt_r - HALF_ONE;
      end
      unique case (state_r)
         ST_IDLE: begin
            edgeCnt_nxt = EDGE_FIRST;
            sclkPhase_nxt = 1'b0;
            if (masterOn && !txEmpty_r) begin
               takeTx = 1'b1; // R7 R14 R15
               sh_nxt = txBuf_r;
               halfCnt_nxt = halfLen - HALF_ONE; // R20
               state_nxt = ST_ACTIVE;
            end else if (selected) begin
               if (!txEmpty_r) begin
                  takeTx = 1'b1;
                  sh_nxt = txBuf_r;
               end
               state_nxt = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (edgeEvt) begin
               sclkPhase_nxt = !sclkPhase_r;
               edgeCnt_nxt = edgeCnt_r + 4'h1;
               if (sampleE) begin
                  latch_nxt = inBit;
                  if (cpha && edgeCnt_r == EDGE_LAST) begin
                     sh_nxt = shiftIn(sh_r, inBit, lsb);
                  end
               end
               if (shiftE) begin
                  sh_nxt = shiftIn(sh_r, latch_r, lsb);
               end
               if (edgeCnt_r == EDGE_LAST) begin
                  complete = 1'b1; // R25
                  shFinal = sh_nxt;
                  state_nxt = c1_r[C1_MASTER] ? ST_TRAIL : ST_IDLE;
               end
            end
            if (!c1_r[C1_MASTER] && !selected) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_TRAIL: begin
            if (tick) begin
               state_nxt = ST_IDLE; // R1
            end
         end
      endcase
      if (!enable || cfgAbort || fault) begin
         state_nxt = ST_IDLE; // R18 R21 R23
         edgeCnt_nxt = EDGE_FIRST;
         sclkPhase_nxt = 1'b0;
         complete = 1'b0;
         takeTx = 1'b0;
         sh_nxt = sh_r;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_r <= ST_IDLE;
         sh_r <= DATA_RESET;
         edgeCnt_r <= EDGE_FIRST;
         halfCnt_r <= HALF_ZERO;
         sclkPhase_r <= 1'b0;
         latch_r <= 1'b0;
         sclkPrev_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         sh_r <= sh_nxt;
         edgeCnt_r <= edgeCnt_nxt;
         halfCnt_r <= halfCnt_nxt;
         sclkPhase_r <= sclkPhase_nxt;
         latch_r <= latch_nxt;
         sclkPrev_r <= sclkPrev_nxt;
      end
   end

   // register file and status flags; hardware sets win over software clears
   always_comb begin
      c1_nxt = c1_r;
      c2_nxt = c2_r;
      baud_nxt = baud_r;
      match_nxt = match_r;
      txBuf_nxt = txBuf_r;
      rxBuf_nxt = rxBuf_r;
      rxFull_nxt = rxFull_r;
      matchFlag_nxt = matchFlag_r;
      txEmpty_nxt = txEmpty_r;
      mode_fault_flag_nxt = mode_fault_flag_r;
      armTx_nxt = armTx_r;
      modfArm_nxt = modfArm_r;
      rsp_nxt.pready = setup;
      rsp_nxt.pslverr = 1'b0;
      rsp_nxt.prdata = '0;
      if (setup) begin
         unique case (apbReq.paddr)
            ADDR_CONTROL_ONE: rsp_nxt.prdata[DATA_W-1:0] = c1_r;
            ADDR_CONTROL_TWO: rsp_nxt.prdata[DATA_W-1:0] = c2_r;
            ADDR_BAUD: rsp_nxt.prdata[DATA_W-1:0] = baud_r;
            ADDR_MATCH: rsp_nxt.prdata[DATA_W-1:0] = match_r;
            ADDR_DATA: rsp_nxt.prdata[DATA_W-1:0] = rxBuf_r; // R5
            ADDR_STATUS: begin
               rsp_nxt.prdata[ST_RXFULL] = rxFull_r;
               rsp_nxt.prdata[ST_MATCH] = matchFlag_r;
               rsp_nxt.prdata[ST_TXEMPTY] = txEmpty_r;
               rsp_nxt.prdata[ST_MODE_FAULT_FLAG] = mode_fault_flag_r;
            end
            default: rsp_nxt.pslverr = 1'b1;
         endcase
      end
      if (rdAcc && apbReq.paddr == ADDR_STATUS) begin
         armTx_nxt = txEmpty_r; // R8
         modfArm_nxt = mode_fault_flag_r;
      end
      if (rdAcc && apbReq.paddr == ADDR_DATA) begin
         rxFull_nxt = 1'b0;
      end
      if (wrAcc) begin
         unique case (apbReq.paddr)
            ADDR_CONTROL_ONE: begin
               c1_nxt = wData;
               if (modfArm_r) begin
                  mode_fault_flag_nxt = 1'b0;
                  modfArm_nxt = 1'b0;
               end
            end
            ADDR_CONTROL_TWO: c2_nxt = wData;
            ADDR_BAUD: baud_nxt = wData;
            ADDR_MATCH: match_nxt = wData;
            ADDR_STATUS: begin
               if (wData[ST_MATCH]) begin
                  matchFlag_nxt = 1'b0;
               end
            end
            ADDR_DATA: begin
               if (armTx_r) begin
                  txBuf_nxt = wData; // R7 R8
                  txEmpty_nxt = 1'b0;
                  armTx_nxt = 1'b0;
               end
            end
            default: ;
         endcase
      end
      if (takeTx) begin
         txEmpty_nxt = 1'b1;
      end
      if (complete && !rxFull_r) begin
         rxBuf_nxt = shFinal; // R12 R9
         rxFull_nxt = 1'b1;
         if (shFinal == match_r) begin
            matchFlag_nxt = 1'b1; // R6
         end
      end
      if (fault) begin
         c1_nxt[C1_MASTER] = 1'b0; // R18
         mode_fault_flag_nxt = 1'b1;
      end
      if (!enable) begin
         rxFull_nxt = 1'b0; // R23
         matchFlag_nxt = 1'b0;
         mode_fault_flag_nxt = 1'b0;
         txEmpty_nxt = 1'b1;
         armTx_nxt = 1'b0;
         modfArm_nxt = 1'b0;
      end
      irq_nxt = (c1_r[C1_IRQ_EN] && (rxFull_r || mode_fault_flag_r)) ||
                (c1_r[C1_TX_IRQ_EN] && enable && txEmpty_r); // R19
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rsp_r <= '0;
         c1_r <= C1_RESET;
         c2_r <= C2_RESET;
         baud_r <= BAUD_RESET;
         match_r <= MATCH_RESET;
         txBuf_r <= DATA_RESET;
         rxBuf_r <= DATA_RESET;
         rxFull_r <= 1'b0;
         matchFlag_r <= 1'b0;
         txEmpty_r <= 1'b1;
         mode_fault_flag_r <= 1'b0;
         armTx_r <= 1'b0;
         modfArm_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         rsp_r <= rsp_nxt;
         c1_r <= c1_nxt;
         c2_r <= c2_nxt;
         baud_r <= baud_nxt;
         match_r <= match_nxt;
         txBuf_r <= txBuf_nxt;
         rxBuf_r <= rxBuf_nxt;
         rxFull_r <= rxFull_nxt;
         matchFlag_r <= matchFlag_nxt;
         txEmpty_r <= txEmpty_nxt;
         mode_fault_flag_r <= mode_fault_flag_nxt;
         armTx_r <= armTx_nxt;
         modfArm_r <= modfArm_nxt;
         irq_r <= irq_nxt;
      end
   end

   // pin drivers; nothing is driven while the port is disabled
   always_comb begin
      pinOut_nxt = '0;
      pinOut_nxt.select_output_enable = autoSs; // R2 R3 R11
      pinOut_nxt.ssOut = (state_r == ST_IDLE); // R17
      pinOut_nxt.sclkOe = masterOn;
      pinOut_nxt.sclkOut = c1_r[C1_CPOL] ^ sclkPhase_r; // R13 R24
      if (masterOn) begin
         // hold the last bit while the slave samples on the final edge
         pinOut_nxt.mosiOut = (state_r == ST_TRAIL) ? pinOut_r.mosiOut : outBit; // R13
         pinOut_nxt.mosiOe = !single_wire_pin_mode || c2_r[C2_BIDIR_OUTPUT_ENABLE];
      end else if (selected) begin
         pinOut_nxt.misoOut = outBit;
         pinOut_nxt.misoOe = !single_wire_pin_mode || c2_r[C2_BIDIR_OUTPUT_ENABLE];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pinOut_r <= '0;
      end else begin
         pinOut_r <= pinOut_nxt;
      end
   end

   assign apbRsp = rsp_r;
   assign pinOut = pinOut_r;
   assign irq = irq_r;

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence seqMasterStart;
      masterOn && state_r == ST_IDLE && !txEmpty_r && !cfgAbort && !fault;
   endsequence

   sequence seqOutputsReleased;
      !pinOut_r.sclkOe && !pinOut_r.mosiOe;
   endsequence

   AST_LEAD_DELAY: assert property (seqMasterStart |=> // R20
      state_r == ST_ACTIVE && sclkPhase_r == 1'b0 && edgeCnt_r == EDGE_FIRST &&
      halfCnt_r == $past(halfLen) - HALF_ONE)
      else $error("clock started without half period delay");
   AST_WR_IGNORED: assert property (wrAcc && apbReq.paddr == ADDR_DATA && !armTx_r |=> // R8
      txBuf_r == $past(txBuf_r) && (txEmpty_r == $past(txEmpty_r) || $past(takeTx)))
      else $error("unarmed data write was taken");
   AST_RX_KEEP: assert property (complete && rxFull_r |=> rxBuf_r == $past(rxBuf_r)) // R9
      else $error("full receive buffer was overwritten");
   AST_RX_LOAD: assert property (complete && !rxFull_r |=> // R12
      rxFull_r && rxBuf_r == $past(shFinal))
      else $error("completed byte not loaded");
   AST_MATCH: assert property (complete && !rxFull_r && shFinal == match_r |=> // R6
      matchFlag_r)
      else $error("match flag not set");
   AST_FAULT: assert property (fault |=> // R18
      !c1_r[C1_MASTER] && mode_fault_flag_r && state_r == ST_IDLE ##1 seqOutputsReleased)
      else $error("mode fault not handled");
   AST_ABORT: assert property (cfgAbort |=> state_r == ST_IDLE) // R21
      else $error("config change did not abort");
   AST_SS_AUTO: assert property (autoSs && state_r == ST_ACTIVE |=> !pinOut_r.ssOut) // R17
      else $error("auto select not low during transfer");
   AST_SCLK_IDLE: assert property (masterOn && state_r == ST_IDLE ##1 state_r == ST_IDLE |=> // R24
      pinOut_r.sclkOut == $past(c1_r[C1_CPOL]))
      else $error("idle clock level wrong");
   AST_DISABLE: assert property (!enable |=> !rxFull_r && !mode_fault_flag_r && txEmpty_r) // R23
      else $error("flags not reset while disabled");
endmodule
`default_nettype wire

// [spi_slave_model.sv]
// spi_slave_model: behavioural serial slave on the far side of the port
// assumes pins resolved by the bench and sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic ss,
   input wire logic sclk,
   input wire logic cpha,
   input wire logic lsbFirst,
   input wire logic mosi,
   input wire logic [7:0] txByte,
   output logic miso,
   output logic [7:0] rxByte,
   output logic [4:0] edges
);
   logic sclkPrev, lastBit;
   logic [3:0] shifts;
   logic [2:0] idx;
   assign idx = 3'(shifts - {3'h0, cpha});
   // released line shows the inverse of the last driven bit
   assign miso = ss ? ~lastBit : (lsbFirst ? txByte[idx] : txByte[3'h7 - idx]);
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sclkPrev <= 1'b0;
         lastBit <= 1'b0;
         shifts <= 4'h0;
         edges <= 5'h00;
         rxByte <= 8'h00;
      end else begin
         sclkPrev <= sclk;
         lastBit <= ss ? lastBit : miso;
         if (ss) begin
            shifts <= 4'h0;
            edges <= 5'h00;
         end else if (sclk != sclkPrev) begin
            edges <= edges + 5'h01;
            if (edges[0] == cpha) begin
               rxByte <= lsbFirst ? {mosi, rxByte[7:1]} : {rxByte[6:0], mosi};
            end else begin
               shifts <= shifts + 4'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// [tb_spi_master_slave_port.sv]
// tb_spi_master_slave_port: self-checking bench, APB master, random bytes
// assumes the slave model on the pins; undriven select and mosi idle high, undriven sclk idles at cpolPin
`timescale 1ns/1ps
`default_nettype none
module tb_spi_master_slave_port;
   import spi_port_pkg::*;
   logic clk, reset, irq, ssExt, cpolPin, cpha, lsbFirst, slaveMiso, err, ssPin, sclkPin;
   logic [7:0] slaveTx, slaveRx, rdVal, b;
   logic [4:0] edges;
   apb_req_type apbReq;
   apb_rsp_type apbRsp;
   pin_in_type pinIn;
   pin_out_type pinOut;
   int nFail, checksDone;
   assign ssPin = pinOut.select_output_enable ? pinOut.ssOut : ssExt;
   assign sclkPin = pinOut.sclkOe ? pinOut.sclkOut : cpolPin;
   assign pinIn = {ssPin, sclkPin, (pinOut.mosiOe ? pinOut.mosiOut : 1'b1),
      (pinOut.misoOe ? pinOut.misoOut : slaveMiso)};
   spi_master_slave_port u_dut (.clk(clk), .reset(reset), .apbReq(apbReq), .apbRsp(apbRsp),
      .pinIn(pinIn), .pinOut(pinOut), .irq(irq));
   spi_slave_model u_slave (.clk(clk), .reset(reset), .ss(ssPin), .sclk(sclkPin), .cpha(cpha),
      .lsbFirst(lsbFirst), .mosi(pinIn.mosi), .txByte(slaveTx), .miso(slaveMiso),
      .rxByte(slaveRx), .edges(edges));
   always #4 clk = ~clk;
   task automatic test_done;
      $display("checks %0d mismatches %0d", checksDone, nFail);
      if (nFail == 0 && checksDone > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checksDone++;
      if (got !== exp) begin
         nFail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
      apbReq.psel <= 1'b1;
      apbReq.penable <= 1'b0;
      apbReq.pwrite <= wr;
      apbReq.paddr <= addr;
      apbReq.pwdata <= {24'h000000, wd};
      @(posedge clk);
      apbReq.penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (apbRsp.pready !== 1'b1);
      rdVal = apbRsp.prdata[7:0];
      err = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      @(posedge clk);
   endtask
   // arm by status read, write the byte, wait for select to return high
   task automatic xfer(input logic [7:0] d);
      apb(1'b0, ADDR_STATUS, 8'h00);
      apb(1'b1, ADDR_DATA, d);
      while (ssPin !== 1'b0) begin
         @(posedge clk);
      end
      chk(8'(sclkPin), 8'(cpolPin));
      while (ssPin !== 1'b1) begin
         @(posedge clk);
      end
      chk(8'(edges), 8'h10);
   endtask
   initial begin
      // eleven transfers of under two hundred cycles each
      repeat (40000) @(posedge clk);
      nFail++;
      test_done();
   end
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      apbReq = '0;
      {ssExt, cpolPin, cpha, lsbFirst} = 4'h8;
      slaveTx = 8'h00;
      nFail = 0;
      checksDone = 0;
      void'($urandom(15757));
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      apb(1'b0, ADDR_CONTROL_ONE, 8'h00);
      chk(rdVal, C1_RESET);
      apb(1'b0, ADDR_MATCH, 8'h00);
      chk(rdVal, 8'h00);
      apb(1'b0, ADDR_DATA, 8'h00);
      chk(rdVal, 8'h00);
      apb(1'b0, 8'h18, 8'h00);
      chk({7'h00, err}, 8'h01);
      chk(rdVal, 8'h00);
      apb(1'b1, ADDR_BAUD, 8'h03);
      apb(1'b1, ADDR_CONTROL_TWO, 8'h10);
      apb(1'b1, ADDR_CONTROL_ONE, 8'h52);
      @(posedge clk);
      chk({ssPin, pinOut.select_output_enable, pinOut.sclkOe}, 8'h07);
      apb(1'b1, ADDR_DATA, 8'ha5);
      repeat (200) @(posedge clk);
      apb(1'b0, ADDR_STATUS, 8'h00);
      chk(rdVal, 8'h20);
      $display("reset and ignored write done");
      for (int m = 0; m < 8; m++) begin
         b = 8'($urandom);
         slaveTx = 8'($urandom);
         {lsbFirst, cpha, cpolPin} <= 3'(m);
         apb(1'b1, ADDR_MATCH, m[0] ? slaveTx : ~slaveTx);
         apb(1'b1, ADDR_CONTROL_ONE, {4'h5, m[0], m[1], 1'b1, m[2]});
         @(posedge clk);
         chk(8'(sclkPin), 8'(m[0]));
         xfer(b);
         chk(slaveRx, b);
         apb(1'b0, ADDR_STATUS, 8'h00);
         chk(rdVal & 8'hc0, m[0] ? 8'hc0 : 8'h80);
         apb(1'b0, ADDR_DATA, 8'h00);
         chk(rdVal, slaveTx);
         apb(1'b1, ADDR_STATUS, 8'h40);
      end
      $display("clock formats done");
      slaveTx = 8'h3c;
      xfer(8'($urandom));
      slaveTx = 8'hc3;
      xfer(8'($urandom));
      apb(1'b0, ADDR_DATA, 8'h00);
      chk(rdVal, 8'h3c);
      apb(1'b0, ADDR_STATUS, 8'h00);
      chk(rdVal & 8'h80, 8'h00);
      $display("overrun done");
      apb(1'b1, ADDR_DATA, 8'h5a);
      repeat (40) @(posedge clk);
      {lsbFirst, cpha, cpolPin} <= 3'h0;
      apb(1'b1, ADDR_CONTROL_ONE, 8'h52);
      repeat (4) @(posedge clk);
      chk(8'(ssPin), 8'h01);
      repeat (300) @(posedge clk);
      apb(1'b0, ADDR_STATUS, 8'h00);
      chk(rdVal & 8'h80, 8'h00);
      xfer(8'h11);
      apb(1'b1, ADDR_CONTROL_ONE, 8'h12);
      apb(1'b0, ADDR_STATUS, 8'h00);
      chk(rdVal & 8'hd0, 8'h00);
      chk({pinOut.select_output_enable, pinOut.sclkOe, pinOut.mosiOe, pinOut.misoOe}, 8'h00);
      $display("abort and disable done");
      apb(1'b1, ADDR_CONTROL_ONE, 8'hd0);
      chk(8'(pinOut.select_output_enable), 8'h00);
      ssExt <= 1'b0;
      repeat (8) @(posedge clk);
      ssExt <= 1'b1;
      chk({irq, pinOut.sclkOe, pinOut.mosiOe}, 8'h04);
      apb(1'b0, ADDR_CONTROL_ONE, 8'h00);
      chk(rdVal & 8'h10, 8'h00);
      apb(1'b0, ADDR_STATUS, 8'h00);
      chk(rdVal & 8'h10, 8'h10);
      apb(1'b1, ADDR_CONTROL_TWO, 8'h00);
      apb(1'b1, ADDR_CONTROL_ONE, 8'h52);
      chk(8'(pinOut.select_output_enable), 8'h00);
      $display("mode fault done");
      test_done();
   end
endmodule
`default_nettype wire
